// ### logic/rse_core.sv
/*
 Execution block for rotate-through-carry, literal-minus-accumulator and
 sleep, with its accumulator, a small file register bank, status flags and
 watchdog, all reached over an AHB-Lite slave port.
 Assumes one AHB-Lite master, hclk at 100 MHz, and that clk_en stays high
 while a bus transfer is in flight.
*/
`timescale 1ns/1ps

module rse_core
	import rse_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic clk_en,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic wake_pin,
	output logic core_asleep,
	output logic osc_run
);

	// ----------------------------------------------------------------
	// Decode helpers
	// ----------------------------------------------------------------
	function automatic logic [2:0] reg_sel(input logic [7:0] a, input logic up0);
		// 0 none, 1 instr, 2 acc, 3 status, 4 wdog, 5 file
		if (!up0) begin
			reg_sel = 3'h0;
		end else if (a[7:6] == RSE_FILE_REGION) begin
			reg_sel = 3'h5;
		end else if (a == RSE_OFF_INSTR) begin
			reg_sel = 3'h1;
		end else if (a == RSE_OFF_ACC) begin
			reg_sel = 3'h2;
		end else if (a == RSE_OFF_STATUS) begin
			reg_sel = 3'h3;
		end else if (a == RSE_OFF_WDOG) begin
			reg_sel = 3'h4;
		end else begin
			reg_sel = 3'h0;
		end
	endfunction

	function automatic rse_exec_t exec_decode(input logic [13:0] ins);
		if (ins == RSE_SLEEP_CODE) begin
			exec_decode = RSE_EX_SLEEP;
		end else if (ins[13:12] == RSE_PFX_FILE && ins[11:8] == RSE_OP_ROT_LEFT) begin
			exec_decode = RSE_EX_ROTL;
		end else if (ins[13:12] == RSE_PFX_FILE && ins[11:8] == RSE_OP_ROT_RIGHT) begin
			exec_decode = RSE_EX_ROTR;
		end else if (ins[13:12] == RSE_PFX_LIT && ins[11:9] == RSE_OP_LIT_SUB) begin
			exec_decode = RSE_EX_SUB;
		end else begin
			exec_decode = RSE_EX_NONE;
		end
	endfunction

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	rse_dphase_t dphase_reg;
	logic read_wait_reg;
	logic [31:0] hrdata_reg;
	logic [7:0] acc_reg;
	logic [7:0] file_mem [RSE_FILE_DEPTH];
	rse_status_t status_reg;
	logic [7:0] wdog_reg;
	logic [7:0] presc_reg;
	rse_state_t state_reg;
	logic [1:0] wake_sync_reg;

	logic addr_take;
	logic [2:0] dsel;
	logic [RSE_FILE_IDX_W-1:0] dfile_idx;
	logic bus_wr;
	logic [13:0] instr;
	rse_exec_t exec_op;
	logic exec_fire;
	logic [RSE_FILE_IDX_W-1:0] op_idx;
	logic [7:0] operand;
	logic [7:0] literal;
	logic [7:0] result;
	logic carry_next;
	logic nibble_next;
	logic [8:0] sub_full;
	logic [4:0] sub_low;
	logic wdog_wrap;
	logic wake;

	// ----------------------------------------------------------------
	// AHB-Lite slave
	// ----------------------------------------------------------------
	assign addr_take = hsel && hready && htrans[1];
	assign dsel = reg_sel(dphase_reg.addr, dphase_reg.upper_zero);
	assign dfile_idx = dphase_reg.addr[RSE_FILE_IDX_W+1:2];
	assign bus_wr = dphase_reg.active && dphase_reg.write;
	// Reads take one wait state so that hrdata comes from a flop and
	// still sees a write made in the cycle just before.
	assign hreadyout = !(dphase_reg.active && !dphase_reg.write && !read_wait_reg);
	assign hresp = 1'b0;
	assign hrdata = hrdata_reg;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dphase_reg <= '0;
		end else if (clk_en) begin
			if (hreadyout) begin
				dphase_reg.active <= addr_take;
				dphase_reg.write <= hwrite;
				dphase_reg.addr <= haddr[7:0];
				dphase_reg.upper_zero <= (haddr[31:8] == 24'h00_0000);
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			read_wait_reg <= 1'b0;
		end else if (clk_en) begin
			read_wait_reg <= dphase_reg.active && !dphase_reg.write && !read_wait_reg;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_reg <= 32'h0000_0000;
		end else if (clk_en && dphase_reg.active && !dphase_reg.write && !read_wait_reg) begin
			unique case (dsel)
				3'h2: hrdata_reg <= {24'h00_0000, acc_reg};
				3'h3: hrdata_reg <= {27'h000_0000, status_reg};
				3'h4: hrdata_reg <= {16'h0000, presc_reg, wdog_reg};
				3'h5: hrdata_reg <= {24'h00_0000, file_mem[dfile_idx]};
				3'h1: hrdata_reg <= {31'h0000_0000, state_reg == RSE_SLEEP};
				default: hrdata_reg <= 32'h0000_0000;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Instruction execution
	// ----------------------------------------------------------------
	assign instr = hwdata[RSE_INSTR_W-1:0];
	assign exec_op = exec_decode(instr);
	// Instructions written while asleep are dropped
	assign exec_fire = bus_wr && dsel == 3'h1 && state_reg == RSE_RUN;
	// Only 16 file registers exist: the file address wraps on its low bits
	assign op_idx = instr[RSE_FILE_IDX_W-1:0];
	assign operand = file_mem[op_idx];
	assign literal = instr[7:0];
	assign sub_full = {1'b0, literal} + {1'b0, ~acc_reg} + 9'h001;
	assign sub_low = {1'b0, literal[3:0]} + {1'b0, ~acc_reg[3:0]} + 5'h01;

	always_comb begin
		result = operand;
		carry_next = status_reg.carry;
		nibble_next = status_reg.nibble;
		unique case (exec_op)
			RSE_EX_ROTL: begin
				result = {operand[6:0], status_reg.carry};
				carry_next = operand[7];
			end
			RSE_EX_ROTR: begin
				result = {status_reg.carry, operand[7:1]};
				carry_next = operand[0];
			end
			RSE_EX_SUB: begin
				result = sub_full[7:0];
				carry_next = sub_full[8];
				nibble_next = sub_low[4];
			end
			RSE_EX_SLEEP, RSE_EX_NONE: begin
				result = operand;
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			acc_reg <= RSE_ACC_RST;
		end else if (clk_en) begin
			if (exec_fire && exec_op == RSE_EX_SUB) begin
				acc_reg <= result;
			end else if (exec_fire && (exec_op == RSE_EX_ROTL || exec_op == RSE_EX_ROTR)
				&& !instr[RSE_DEST_BIT]) begin
				acc_reg <= result;
			end else if (bus_wr && dsel == 3'h2) begin
				acc_reg <= hwdata[7:0];
			end
		end
	end

	for (genvar i = 0; i < RSE_FILE_DEPTH; i++) begin : g_file
		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				file_mem[i] <= RSE_FILE_RST;
			end else if (clk_en) begin
				if (exec_fire && (exec_op == RSE_EX_ROTL || exec_op == RSE_EX_ROTR)
					&& instr[RSE_DEST_BIT] && op_idx == RSE_FILE_IDX_W'(i)) begin
					file_mem[i] <= result;
				end else if (bus_wr && dsel == 3'h5 && dfile_idx == RSE_FILE_IDX_W'(i)) begin
					file_mem[i] <= hwdata[7:0];
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Status flags
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			status_reg <= RSE_STATUS_RST;
		end else if (clk_en) begin
			if (exec_fire) begin
				status_reg.carry <= carry_next;
				status_reg.nibble <= nibble_next;
				if (exec_op == RSE_EX_SUB) begin
					status_reg.zero <= (sub_full[7:0] == 8'h00);
				end
			end else if (bus_wr && dsel == 3'h3) begin
				// Software may preset the arithmetic flags only
				status_reg.carry <= hwdata[0];
				status_reg.nibble <= hwdata[1];
				status_reg.zero <= hwdata[2];
			end
			if (exec_fire && exec_op == RSE_EX_SLEEP) begin
				status_reg.powerdown <= 1'b0;
				status_reg.timeout <= 1'b1;
			end else if (wdog_wrap) begin
				status_reg.timeout <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Watchdog counter and prescaler
	// ----------------------------------------------------------------
	assign wdog_wrap = (wdog_reg == 8'hff) && (presc_reg == 8'hff);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wdog_reg <= RSE_WDOG_CLR;
			presc_reg <= RSE_PRESC_CLR;
		end else if (clk_en) begin
			// Sleep clear wins over the running count
			if (exec_fire && exec_op == RSE_EX_SLEEP) begin
				wdog_reg <= RSE_WDOG_CLR;
				presc_reg <= RSE_PRESC_CLR;
			end else begin
				presc_reg <= presc_reg + 8'h01;
				if (presc_reg == 8'hff) begin
					wdog_reg <= wdog_reg + 8'h01;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Run / sleep control
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wake_sync_reg <= 2'h0;
		end else if (clk_en) begin
			wake_sync_reg <= {wake_sync_reg[0], wake_pin};
		end
	end

	assign wake = wake_sync_reg[1] || wdog_wrap;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg <= RSE_RUN;
		end else if (clk_en) begin
			unique case (state_reg)
				RSE_RUN: begin
					if (exec_fire && exec_op == RSE_EX_SLEEP) begin
						state_reg <= RSE_SLEEP;
					end
				end
				RSE_SLEEP: begin
					if (wake) begin
						state_reg <= RSE_RUN;
					end
				end
				default: state_reg <= RSE_RUN;
			endcase
		end
	end

	// The watchdog keeps hclk-based counting in sleep; only the core
	// oscillator request drops, the block itself is not clock gated here.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			core_asleep <= 1'b0;
			osc_run <= 1'b1;
		end else if (clk_en) begin
			core_asleep <= (state_reg == RSE_SLEEP);
			osc_run <= (state_reg != RSE_SLEEP);
		end
	end

	logic unused_ok;
	assign unused_ok = ^{hsize, hwdata[31:RSE_INSTR_W]};

endmodule // rse_core

// ### logic/rse_pkg.sv
/*
 Package for the rotate / literal-subtract / sleep execution block: register
 offsets, reset values, opcode patterns, status layout and shared types.
 Assumes a single AHB-Lite master and one clock domain.
*/
// What this block does
// - The rotate-left opcode shifts the file register left, old bit 7 into carry, carry into bit 0.
// - A rotate with destination bit 0 writes the accumulator and leaves the file register alone.
// - A rotate with destination bit 1 writes the result back into the source file register.
// - The sleep opcode clears the powerdown flag in one single-cycle instruction.
// - The sleep opcode sets the timeout flag.
// - The sleep opcode clears the watchdog counter to zero and clears its prescaler.
// - The literal-subtract opcode computes the literal minus the accumulator in two's complement.
// - The literal-subtract result always goes to the accumulator.
// - The literal-subtract updates carry, nibble carry and zero from its result.
// - After subtraction carry is 1 for a zero or positive result and 0 on a borrow.
package rse_pkg;

	// ----------------------------------------------------------------
	// Register map (byte offsets)
	// ----------------------------------------------------------------
	localparam logic [7:0] RSE_OFF_INSTR = 8'h00;
	localparam logic [7:0] RSE_OFF_ACC = 8'h04;
	localparam logic [7:0] RSE_OFF_STATUS = 8'h08;
	localparam logic [7:0] RSE_OFF_WDOG = 8'h0c;
	localparam logic [1:0] RSE_FILE_REGION = 2'h1;
	localparam int RSE_FILE_DEPTH = 16;
	localparam int RSE_FILE_IDX_W = 4;

	// ----------------------------------------------------------------
	// Instruction fields and opcodes
	// ----------------------------------------------------------------
	localparam int RSE_INSTR_W = 14;
	localparam int RSE_DEST_BIT = 7;
	localparam logic [3:0] RSE_OP_ROT_LEFT = 4'hd;
	localparam logic [3:0] RSE_OP_ROT_RIGHT = 4'hc;
	localparam logic [1:0] RSE_PFX_FILE = 2'h0;
	localparam logic [1:0] RSE_PFX_LIT = 2'h3;
	localparam logic [2:0] RSE_OP_LIT_SUB = 3'h6;
	localparam logic [13:0] RSE_SLEEP_CODE = 14'h0063;

	// ----------------------------------------------------------------
	// Reset and clear values
	// ----------------------------------------------------------------
	localparam logic [7:0] RSE_ACC_RST = 8'h00;
	localparam logic [4:0] RSE_STATUS_RST = 5'h18;
	localparam logic [7:0] RSE_WDOG_CLR = 8'h00;
	localparam logic [7:0] RSE_PRESC_CLR = 8'h00;
	localparam logic [7:0] RSE_FILE_RST = 8'h00;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic timeout;
		logic powerdown;
		logic zero;
		logic nibble;
		logic carry;
	} rse_status_t;

	typedef enum logic [1:0] {
		RSE_RUN = 2'b01,
		RSE_SLEEP = 2'b10
	} rse_state_t;

	typedef enum logic [4:0] {
		RSE_EX_NONE = 5'b00001,
		RSE_EX_ROTL = 5'b00010,
		RSE_EX_ROTR = 5'b00100,
		RSE_EX_SLEEP = 5'b01000,
		RSE_EX_SUB = 5'b10000
	} rse_exec_t;

	typedef struct packed {
		logic active;
		logic write;
		logic [7:0] addr;
		logic upper_zero;
	} rse_dphase_t;

endpackage

// ### verification/rse_core_props.sv
/*
 Checker for rse_core: bus answer timing, sleep entry, oscillator halt and wake.
 Assumes hready is tied to hreadyout and clk_en stays high during transfers.
*/
`timescale 1ns/1ps
module rse_core_props
	import rse_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic clk_en,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic wake_pin,
	input wire logic core_asleep,
	input wire logic osc_run
);
	// ----------------------------------------
	// Data phase tracking
	// ----------------------------------------
	logic taken;
	logic dp_rd;
	logic dp_ins;
	logic sleep_go;
	assign taken = hsel & hready & htrans[1] & clk_en;
	assign sleep_go = dp_ins & (hwdata[13:0] == RSE_SLEEP_CODE) & clk_en & !core_asleep & !wake_pin;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_rd <= 1'b0;
			dp_ins <= 1'b0;
		end else if (clk_en) begin
			dp_rd <= taken & !hwrite;
			dp_ins <= taken & hwrite & (haddr == 32'h0000_0000);
		end
	end
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	a_okay_resp: assert property (hresp == 1'b0) else $error("error response seen");
	a_write_nowait: assert property (taken && hwrite |=> hreadyout)
		else $error("write data phase stalled");
	a_read_wait: assert property (taken && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	a_idle_ready: assert property (!dp_rd |-> hreadyout) else $error("stall outside read");
	a_rdata_hold: assert property (!dp_rd |=> $stable(hrdata)) else $error("read data moved");
	a_sleep_enter: assert property (sleep_go |-> ##[1:3] core_asleep)
		else $error("sleep not entered");
	a_osc_halt: assert property (sleep_go |-> ##[1:3] !osc_run)
		else $error("oscillator kept running");
	a_osc_pair: assert property (core_asleep == !osc_run)
		else $error("oscillator and sleep disagree");
	a_stay_asleep: assert property (core_asleep && !wake_pin && !$past(wake_pin)
		&& !$past(wake_pin, 2) && !$past(wake_pin, 3) |=> core_asleep)
		else $error("left sleep without wake");
	a_wake_exit: assert property (core_asleep && $rose(wake_pin) |-> ##[1:6] !core_asleep)
		else $error("wake ignored");
	c_sleep: cover property (sleep_go);
	c_read: cover property (taken && !hwrite);
	c_wake: cover property (core_asleep && $rose(wake_pin));
endmodule // rse_core_props

bind rse_core rse_core_props u_props (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en),
	.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
	.hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
	.wake_pin(wake_pin), .core_asleep(core_asleep), .osc_run(osc_run));

// ### verification/testbench.sv
/*
 Self-checking bench for rse_core: instruction rows, then reset, sleep and wake.
 Assumes the slave answers each transfer within a few cycles.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
	$display("BAD %s exp %h got %h", nm, e, g); end end
module testbench
	import rse_pkg::*;
;
	typedef struct packed {
		logic [13:0] ins;
		logic [7:0] acc;
		logic [7:0] fin;
		logic [2:0] st;
		logic [7:0] eacc;
		logic [7:0] ef;
		logic [2:0] est;
	} rse_row_t;
	localparam logic [31:0] NIL32 = 32'h0000_0000;
	logic hclk, hresetn, clk_en, hsel, hwrite, wake_pin, hreadyout, hresp, core_asleep, osc_run;
	logic rdy_n;
	logic [31:0] haddr, hwdata, hrdata, rd, rd_n;
	logic [1:0] htrans;
	logic [15:0] t0, t1;
	int n_fail, comparisons, cyc;
	rse_row_t rows [8];

	rse_core DUT (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .wake_pin(wake_pin),
		.core_asleep(core_asleep), .osc_run(osc_run));

	// ----------------------------------------
	// Clock, sampling and closing
	// ----------------------------------------
	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end
	// Outputs only move at rising edges, so the falling edge gives a race-free sample
	always @(negedge hclk) begin
		rdy_n <= hreadyout;
		rd_n <= hrdata;
	end
	always @(posedge hclk) begin
		cyc++;
		// One full watchdog wrap plus a few hundred cycles of ordinary tests
		if (cyc == 70000) begin
			n_fail++;
			test_done();
		end
	end
	task test_done;
		$display("counts: %0d failed of %0d compared", n_fail, comparisons);
		if (n_fail == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= {24'h00_0000, a};
		htrans <= 2'b10;
		hwrite <= w;
		do @(posedge hclk); while (rdy_n !== 1'b1);
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge hclk); while (rdy_n !== 1'b1);
		rd = rd_n;
	endtask

	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial begin
		hresetn = 1'b0;
		clk_en = 1'b1;
		hsel = 1'b0;
		haddr = NIL32;
		htrans = 2'b00;
		hwrite = 1'b0;
		hwdata = NIL32;
		wake_pin = 1'b0;
		rows = '{'{14'h0d05, 8'h00, 8'h81, 3'h6, 8'h02, 8'h81, 3'h7},
			'{14'h0d85, 8'h33, 8'h40, 3'h1, 8'h33, 8'h81, 3'h0},
			'{14'h0c05, 8'h55, 8'h01, 3'h0, 8'h00, 8'h01, 3'h1},
			'{14'h0c85, 8'h77, 8'h80, 3'h1, 8'h77, 8'hc0, 3'h0},
			'{14'h3c02, 8'h01, 8'h11, 3'h4, 8'h01, 8'h11, 3'h3},
			'{14'h3c01, 8'h02, 8'h11, 3'h7, 8'hff, 8'h11, 3'h0},
			'{14'h3d10, 8'h10, 8'h11, 3'h0, 8'h00, 8'h11, 3'h7},
			'{14'h3c10, 8'h01, 8'h11, 3'h6, 8'h0f, 8'h11, 3'h1}};
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		foreach (rows[i]) begin
			bus(1'b1, RSE_OFF_ACC, 32'(rows[i].acc));
			bus(1'b1, RSE_OFF_STATUS, 32'(rows[i].st));
			bus(1'b1, 8'h54, 32'(rows[i].fin));
			bus(1'b1, RSE_OFF_INSTR, 32'(rows[i].ins));
			bus(1'b0, RSE_OFF_ACC, NIL32);
			`CHK("acc", 32'(rows[i].eacc), rd)
			bus(1'b0, RSE_OFF_STATUS, NIL32);
			`CHK("status", 32'h0000_0018 | 32'(rows[i].est), rd)
			bus(1'b0, 8'h54, NIL32);
			`CHK("file", 32'(rows[i].ef), rd)
			$display("row %0d done", i);
		end
		// Second reset in mid-run
		hresetn <= 1'b0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		bus(1'b0, RSE_OFF_STATUS, NIL32);
		`CHK("status_rst", 32'h0000_0018, rd)
		bus(1'b0, RSE_OFF_ACC, NIL32);
		`CHK("acc_rst", NIL32, rd)
		bus(1'b0, 8'h10, NIL32);
		`CHK("unmapped", NIL32, rd)
		$display("reset test done");
		// Let the watchdog advance so that its clearing is visible
		repeat (300) @(posedge hclk);
		bus(1'b0, RSE_OFF_WDOG, NIL32);
		`CHK("wdog_run", 1'b1, rd[7:0] != 8'h00)
		bus(1'b1, RSE_OFF_STATUS, NIL32);
		// Powerdown and timeout are not software writable
		bus(1'b0, RSE_OFF_STATUS, NIL32);
		`CHK("status_ro", 32'h0000_0018, rd)
		bus(1'b1, RSE_OFF_INSTR, 32'(RSE_SLEEP_CODE));
		bus(1'b0, RSE_OFF_STATUS, NIL32);
		`CHK("status_sleep", 32'h0000_0010, rd)
		bus(1'b0, RSE_OFF_WDOG, NIL32);
		`CHK("wdog_clr", 8'h00, rd[7:0])
		`CHK("presc_clr", 1'b1, rd[15:8] < 8'h10)
		bus(1'b1, RSE_OFF_INSTR, 32'h0000_3c05);
		bus(1'b0, RSE_OFF_INSTR, NIL32);
		`CHK("asleep", 1'b1, rd[0])
		`CHK("osc", 1'b0, osc_run)
		bus(1'b0, RSE_OFF_ACC, NIL32);
		`CHK("acc_held", NIL32, rd)
		$display("sleep test done");
		wake_pin <= 1'b1;
		repeat (4) @(posedge hclk);
		wake_pin <= 1'b0;
		for (int k = 0; k < 20 && core_asleep !== 1'b0; k++)
			@(posedge hclk);
		`CHK("woken", 1'b0, core_asleep)
		bus(1'b1, RSE_OFF_INSTR, 32'h0000_3c05);
		bus(1'b0, RSE_OFF_ACC, NIL32);
		`CHK("acc_run", 32'h0000_0005, rd)
		$display("wake test done");
		// Clock enable low must freeze the watchdog like all other state
		bus(1'b0, RSE_OFF_WDOG, NIL32);
		t0 = {rd[7:0], rd[15:8]};
		bus(1'b0, RSE_OFF_WDOG, NIL32);
		t1 = {rd[7:0], rd[15:8]};
		clk_en <= 1'b0;
		repeat (50) @(posedge hclk);
		clk_en <= 1'b1;
		bus(1'b0, RSE_OFF_WDOG, NIL32);
		`CHK("freeze", t1 - t0, {rd[7:0], rd[15:8]} - t1)
		$display("clock enable test done");
		// A watchdog wrap clears timeout, so a second sleep can show it being set
		repeat (65536) @(posedge hclk);
		bus(1'b0, RSE_OFF_STATUS, NIL32);
		`CHK("status_wrap", 32'h0000_0003, rd)
		bus(1'b1, RSE_OFF_INSTR, 32'(RSE_SLEEP_CODE));
		bus(1'b0, RSE_OFF_STATUS, NIL32);
		`CHK("timeout_set", 32'h0000_0013, rd)
		$display("watchdog test done");
		test_done();
	end
endmodule // testbench
